// File: src/agt_regs.sv
`timescale 1ns/1ns
// Functional notes
// [R1] read/write 24-bit self gain correction for gain 32 at 0x1D.
// [R2] read/write 24-bit self gain correction for gain 64 at 0x1E.
// [R3] read/write 24-bit self gain correction for gain 128 at 0x1F.
// [R4] read/write lower limit at 0x20 compared with result 0, flag 0.
// [R5] read/write lower limit at 0x21 compared with result 1, flag 1.
// [R6] read/write lower limit at 0x22 compared with result 2, flag 2.
// [R7] compare uses the current unipolar/bipolar and output format coding.
// [R8] host should rewrite limits after changing the coding settings.
// [R9] flag is high while result is below its limit, low otherwise.
module agt_regs
  import agt_pkg::*;
(
  // clock and reset
  input  wire logic          CLK_IN,
  input  wire logic          RST_IN,
  // serial control interface
  input  wire logic          CS_N_IN,
  input  wire logic          SCLK_IN,
  input  wire logic          MOSI_IN,
  output logic               MISO_OUT,
  output logic               MISO_OE_OUT,
  // coding settings
  input  wire logic          UNIPOLAR_BIPOLAR_SELECT_IN,
  input  wire logic          OFFSET_BINARY_FORMAT_IN,
  // conversion results
  input  wire agt_results_t  CONVERSION_RESULT_IN,
  // to datapath and status
  output agt_gain_cal_t      GAIN_CAL_OUT,
  output logic [NUM_CH-1:0]  UNDER_THRESHOLD_FLAG_OUT
);

  // =============================================================
  // serial frame state
  agt_state_t                          state_d;
  agt_state_t                          state_q;
  logic [5:0]                          cnt_d;
  logic [5:0]                          cnt_q;
  logic [DATA_W-1:0]                   rx_d;
  logic [DATA_W-1:0]                   rx_q;
  logic [ADDR_W-1:0]                   cmd_d;
  logic [ADDR_W-1:0]                   cmd_q;
  logic [DATA_W-1:0]                   tx_d;
  logic [DATA_W-1:0]                   tx_q;
  logic                                miso_d;
  logic                                miso_q;
  logic                                sclk_d;
  logic                                sclk_q;
  logic                                sclk_rise;
  logic                                sclk_fall;
  logic [ADDR_W-1:0]                   cmd_word;
  logic [DATA_W-1:0]                   wr_word;
  logic                                wr_en;
  logic [NUM_REGS-1:0]                 sel;

  // =============================================================
  // register file
  logic [NUM_REGS-1:0][DATA_W-1:0]     regs_d;
  logic [NUM_REGS-1:0][DATA_W-1:0]     regs_q;
  logic [DATA_W-1:0]                   rd_word;

  // =============================================================
  // serial clock edges and shift words
  // sclk is sampled once per clock, so each edge is a one-cycle pulse
  assign sclk_rise = SCLK_IN & ~sclk_q;
  assign sclk_fall = ~SCLK_IN & sclk_q;
  assign cmd_word  = {rx_q[ADDR_W-2:0], MOSI_IN};
  assign wr_word   = {rx_q[DATA_W-2:0], MOSI_IN};
  assign sel       = agt_reg_sel({1'b0, cmd_q[ADDR_W-2:0]});

  // read mux, unmapped reads as zero
  always_comb begin
    logic [NUM_REGS-1:0] rsel;
    rsel = agt_reg_sel({1'b0, cmd_word[ADDR_W-2:0]});
    rd_word = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (rsel[i]) begin
        rd_word = regs_q[i];
      end
    end
  end

  // =============================================================
  // frame sequencer: mode 0, sample on rise, shift out on fall
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    rx_d    = rx_q;
    cmd_d   = cmd_q;
    tx_d    = tx_q;
    miso_d  = miso_q;
    sclk_d  = SCLK_IN;
    wr_en   = 1'b0;
    if (CS_N_IN) begin
      state_d = ST_IDLE;
      cnt_d   = CNT_ZERO;
      miso_d  = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_CMD;
          cnt_d   = CNT_ZERO;
          if (sclk_rise) begin
            rx_d  = {rx_q[DATA_W-2:0], MOSI_IN};
            cnt_d = CNT_ONE;
          end
        end
        ST_CMD: begin
          if (sclk_rise) begin
            rx_d  = {rx_q[DATA_W-2:0], MOSI_IN};
            cnt_d = cnt_q + CNT_ONE;
            if (cnt_q == CNT_CMD_LAST) begin
              cmd_d   = cmd_word;
              state_d = ST_DATA;
              // read word loads at the 8th rise
              if (cmd_word[CMD_READ_BIT]) begin
                tx_d   = rd_word;
                miso_d = rd_word[DATA_W-1];
              end else begin
                tx_d   = '0;
                miso_d = 1'b0;
              end
            end
          end
        end
        ST_DATA: begin
          if (sclk_rise) begin
            rx_d  = {rx_q[DATA_W-2:0], MOSI_IN};
            cnt_d = cnt_q + CNT_ONE;
            if (cnt_q == CNT_FRAME_LAST) begin
              state_d = ST_DONE;
              wr_en   = ~cmd_q[CMD_READ_BIT];
            end
          end else if (sclk_fall && cnt_q > CNT_TX_START) begin
            // bit 23 stands over the fall after the 8th rise
            tx_d   = {tx_q[DATA_W-2:0], 1'b0};
            miso_d = tx_q[DATA_W-2];
          end
        end
        ST_DONE: begin
          miso_d = 1'b0;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_q <= ST_IDLE;
      cnt_q   <= CNT_ZERO;
      rx_q    <= '0;
      cmd_q   <= '0;
      tx_q    <= '0;
      miso_q  <= 1'b0;
      sclk_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      rx_q    <= rx_d;
      cmd_q   <= cmd_d;
      tx_q    <= tx_d;
      miso_q  <= miso_d;
      sclk_q  <= sclk_d;
    end
  end

  // =============================================================
  // register write
  always_comb begin
    regs_d = regs_q;
    for (int i = 0; i < NUM_REGS; i++) begin
      // [R1] [R2] [R3] gain correction writes
      // [R4] [R5] [R6] lower limit writes
      if (wr_en && sel[i]) begin
        regs_d[i] = wr_word;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      regs_q <= {NUM_REGS{REG_RESET_VAL}};
    end else begin
      regs_q <= regs_d;
    end
  end

  // [R1] [R2] [R3] corrections to datapath
  assign GAIN_CAL_OUT.gain32  = regs_q[IDX_GAIN32];
  assign GAIN_CAL_OUT.gain64  = regs_q[IDX_GAIN64];
  assign GAIN_CAL_OUT.gain128 = regs_q[IDX_GAIN128];

  // =============================================================
  // serial data out, driven for the whole selected period
  assign MISO_OUT    = miso_q;
  assign MISO_OE_OUT = ~CS_N_IN;

  // =============================================================
  // lower limit compare per channel
  // [R7] coding orders the compare
  agt_coding_t coding;
  assign coding.unipolar      = UNIPOLAR_BIPOLAR_SELECT_IN;
  assign coding.offset_binary = OFFSET_BINARY_FORMAT_IN;

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_cmp
    // [R4] [R5] [R6] limit against its result
    agt_limit_cmp u_cmp (
      .clk_in    (CLK_IN),
      .rst_in    (RST_IN),
      .result_in (CONVERSION_RESULT_IN[ch]),
      .limit_in  (regs_q[IDX_LIMIT0 + ch]),
      .coding_in (coding),
      .flag_out  (UNDER_THRESHOLD_FLAG_OUT[ch])
    );
  end

endmodule : agt_regs

// File: src/agt_pkg.sv
// =============================================================
// agt_pkg: shared constants and types
package agt_pkg;

  // =============================================================
  // widths
  localparam int DATA_W = 24;
  localparam int ADDR_W = 8;
  localparam int NUM_REGS = 6;
  localparam int NUM_CH = 3;

  // =============================================================
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_GAIN32_SELF_CORRECTION  = 8'h1D;
  localparam logic [ADDR_W-1:0] ADDR_GAIN64_SELF_CORRECTION  = 8'h1E;
  localparam logic [ADDR_W-1:0] ADDR_GAIN128_SELF_CORRECTION = 8'h1F;
  localparam logic [ADDR_W-1:0] ADDR_LOWER_LIMIT_RESULT0     = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_LOWER_LIMIT_RESULT1     = 8'h21;
  localparam logic [ADDR_W-1:0] ADDR_LOWER_LIMIT_RESULT2     = 8'h22;

  // register file indices
  localparam int IDX_GAIN32  = 0;
  localparam int IDX_GAIN64  = 1;
  localparam int IDX_GAIN128 = 2;
  localparam int IDX_LIMIT0  = 3;

  // reset value of every register in this slice
  localparam logic [DATA_W-1:0] REG_RESET_VAL = 24'h000000;

  // =============================================================
  // serial frame layout: one command byte, then 24 data bits, msb first
  localparam int CMD_READ_BIT = 7;
  localparam logic [5:0] CNT_CMD_LAST   = 6'h07;
  localparam logic [5:0] CNT_TX_START   = 6'h08;
  localparam logic [5:0] CNT_FRAME_LAST = 6'h1F;
  localparam logic [5:0] CNT_ZERO       = 6'h00;
  localparam logic [5:0] CNT_ONE        = 6'h01;

  // =============================================================
  // types
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD  = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } agt_state_t;

  typedef struct packed {
    logic [DATA_W-1:0] gain32;
    logic [DATA_W-1:0] gain64;
    logic [DATA_W-1:0] gain128;
  } agt_gain_cal_t;

  typedef struct packed {
    logic unipolar;
    logic offset_binary;
  } agt_coding_t;

  typedef logic [NUM_CH-1:0][DATA_W-1:0] agt_results_t;

  // =============================================================
  // functions
  // maps a code onto an unsigned scale that keeps numeric order
  function automatic logic [DATA_W-1:0] agt_order_key(input logic [DATA_W-1:0] code,
                                                      input agt_coding_t coding);
    logic [DATA_W-1:0] key;
    key = code;
    if (!coding.unipolar && !coding.offset_binary) begin
      key[DATA_W-1] = ~code[DATA_W-1];
    end
    return key;
  endfunction : agt_order_key

  // one-hot register select, all zero for an unmapped address
  function automatic logic [NUM_REGS-1:0] agt_reg_sel(input logic [ADDR_W-1:0] addr);
    logic [NUM_REGS-1:0] sel;
    sel = '0;
    if (addr == ADDR_GAIN32_SELF_CORRECTION) begin
      sel[0] = 1'b1;
    end else if (addr == ADDR_GAIN64_SELF_CORRECTION) begin
      sel[1] = 1'b1;
    end else if (addr == ADDR_GAIN128_SELF_CORRECTION) begin
      sel[2] = 1'b1;
    end else if (addr == ADDR_LOWER_LIMIT_RESULT0) begin
      sel[3] = 1'b1;
    end else if (addr == ADDR_LOWER_LIMIT_RESULT1) begin
      sel[4] = 1'b1;
    end else if (addr == ADDR_LOWER_LIMIT_RESULT2) begin
      sel[5] = 1'b1;
    end
    return sel;
  endfunction : agt_reg_sel

endpackage : agt_pkg

// File: src/agt_limit_cmp.sv
`timescale 1ns/1ns
// =============================================================
// agt_limit_cmp: one channel lower-limit compare
module agt_limit_cmp
  import agt_pkg::*;
(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // compare operands
  input  wire logic [DATA_W-1:0] result_in,
  input  wire logic [DATA_W-1:0] limit_in,
  input  wire agt_coding_t       coding_in,
  // status
  output logic                   flag_out
);

  logic flag_d;
  logic flag_q;

  // [R7] compare in selected coding
  // [R9] flag follows below-limit
  always_comb begin
    flag_d = (agt_order_key(result_in, coding_in) < agt_order_key(limit_in, coding_in));
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_out = flag_q;

endmodule : agt_limit_cmp

// File: verification/agt_chk.sv
`timescale 1ns/1ns
// ====================
// agt_chk: port checks on agt_regs
module agt_chk
  import agt_pkg::*;
(
  // clock and reset
  input wire logic              CLK_IN,
  input wire logic              RST_IN,
  // serial side
  input wire logic              CS_N_IN,
  input wire logic              SCLK_IN,
  input wire logic              MISO_OUT,
  input wire logic              MISO_OE_OUT,
  // compare side
  input wire logic              UNIPOLAR_BIPOLAR_SELECT_IN,
  input wire logic              OFFSET_BINARY_FORMAT_IN,
  input wire agt_results_t      CONVERSION_RESULT_IN,
  input wire agt_gain_cal_t     GAIN_CAL_OUT,
  input wire logic [NUM_CH-1:0] UNDER_THRESHOLD_FLAG_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // largest code of the selected coding is never under a limit
  logic [DATA_W-1:0] tc;
  logic [NUM_CH-1:0] top;
  assign tc = (UNIPOLAR_BIPOLAR_SELECT_IN || OFFSET_BINARY_FORMAT_IN) ? 24'hFFFFFF : 24'h7FFFFF;
  assign top = {CONVERSION_RESULT_IN[2] == tc, CONVERSION_RESULT_IN[1] == tc,
                CONVERSION_RESULT_IN[0] == tc};
  sequence s_idle2; CS_N_IN [*2]; endsequence
  sequence s_idle3; CS_N_IN [*3]; endsequence
  a_top_ch0_clear: assert property ($past(top[0]) |-> !UNDER_THRESHOLD_FLAG_OUT[0])
    else $error("flag 0 set for top code");
  a_top_ch1_clear: assert property ($past(top[1]) |-> !UNDER_THRESHOLD_FLAG_OUT[1])
    else $error("flag 1 set for top code");
  a_top_ch2_clear: assert property ($past(top[2]) |-> !UNDER_THRESHOLD_FLAG_OUT[2])
    else $error("flag 2 set for top code");
  a_gain_after_rise: assert property ($changed(GAIN_CAL_OUT) |->
    $past(SCLK_IN) && !$past(SCLK_IN, 2) && $past(!CS_N_IN))
    else $error("gain changed without a clock rise");
  a_gain_quiet_idle: assert property (s_idle3 |-> $stable(GAIN_CAL_OUT))
    else $error("gain changed while deselected");
  a_flag_input_steady: assert property (s_idle2 ##0 ($past(!RST_IN) &&
    $stable(CONVERSION_RESULT_IN) && $stable(OFFSET_BINARY_FORMAT_IN) &&
    $stable(UNIPOLAR_BIPOLAR_SELECT_IN)) |=> $stable(UNDER_THRESHOLD_FLAG_OUT))
    else $error("flag moved with steady inputs");
  a_miso_idle_zero: assert property (s_idle2 |-> MISO_OUT == 1'b0)
    else $error("miso not low while deselected");
  a_oe_follows_cs: assert property (MISO_OE_OUT == !CS_N_IN)
    else $error("miso enable differs from select");
endmodule : agt_chk

bind agt_regs agt_chk u_chk (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .CS_N_IN(CS_N_IN), .SCLK_IN(SCLK_IN),
  .MISO_OUT(MISO_OUT), .MISO_OE_OUT(MISO_OE_OUT), .GAIN_CAL_OUT(GAIN_CAL_OUT),
  .UNIPOLAR_BIPOLAR_SELECT_IN(UNIPOLAR_BIPOLAR_SELECT_IN),
  .OFFSET_BINARY_FORMAT_IN(OFFSET_BINARY_FORMAT_IN),
  .CONVERSION_RESULT_IN(CONVERSION_RESULT_IN),
  .UNDER_THRESHOLD_FLAG_OUT(UNDER_THRESHOLD_FLAG_OUT)
);

// File: verification/agt_host.sv
`timescale 1ns/1ns
// ====================
// agt_host: serial host, mode 0, one 32-bit frame per select
module agt_host (
  input  wire logic   clk_in,
  input  wire logic   miso_in,
  output logic        cs_n_out,
  output logic        sclk_out,
  output logic        mosi_out,
  output logic        done_out,
  output logic [23:0] word_out
);
  initial begin
    {cs_n_out, sclk_out, mosi_out, done_out} = 4'b1000;
    word_out = 24'h000000;
  end
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd);
    logic [31:0] f;
    logic [23:0] r;
    f = {cmd, wd};
    r = 24'h000000;
    cs_n_out <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      mosi_out <= f[i];
      sclk_out <= 1'b0;
      repeat (3) @(posedge clk_in);
      sclk_out <= 1'b1;
      @(posedge clk_in);
      r = {r[22:0], miso_in};
      @(posedge clk_in);
    end
    sclk_out <= 1'b0;
    // released data line shows the inverse of its last bit
    mosi_out <= ~f[0];
    repeat (3) @(posedge clk_in);
    cs_n_out <= 1'b1;
    word_out <= r;
    done_out <= 1'b1;
    @(posedge clk_in);
    done_out <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : xfer
endmodule : agt_host

// File: verification/agt_regs_test.sv
`timescale 1ns/1ns
// ====================
// agt_regs_test: register access and limit compare
module agt_regs_test
  import agt_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              uni = 1'b1;
  logic              off = 1'b0;
  agt_results_t      res = '0;
  logic              cs_n, sclk, mosi, miso, miso_oe, miso_w, done;
  logic [23:0]       word;
  logic [23:0]       val[7];
  logic [23:0]       lim[NUM_CH];
  agt_gain_cal_t     gain;
  logic [NUM_CH-1:0] flag;
  logic [23:0]       exp_q[$];
  int                checks = 0;
  int                n_mismatch = 0;
  always #4 clk = ~clk;
  assign miso_w = miso_oe ? miso : 1'b1;
  agt_regs dut (
    .CLK_IN(clk), .RST_IN(rst), .CS_N_IN(cs_n), .SCLK_IN(sclk), .MOSI_IN(mosi),
    .MISO_OUT(miso), .MISO_OE_OUT(miso_oe), .UNIPOLAR_BIPOLAR_SELECT_IN(uni),
    .OFFSET_BINARY_FORMAT_IN(off), .CONVERSION_RESULT_IN(res), .GAIN_CAL_OUT(gain),
    .UNDER_THRESHOLD_FLAG_OUT(flag)
  );
  agt_host host (
    .clk_in(clk), .miso_in(miso_w), .cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi),
    .done_out(done), .word_out(word)
  );
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    exp_q.push_back(e);
    host.xfer(8'h80 | a, 24'($urandom));
  endtask : rd
  function automatic logic [23:0] key(input logic [23:0] v);
    return (!uni && !off) ? v ^ 24'h800000 : v;
  endfunction : key
  task automatic stop_test;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // ====================
  // read monitor takes the oldest expected word
  always @(posedge clk) begin
    if (done === 1'b1 && exp_q.size() > 0) begin
      chk("read", exp_q.pop_front(), word);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
  initial begin
    void'($urandom(10));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 7; i++) rd(8'h1D + 8'(i), 24'h000000);
    for (int i = 0; i < 7; i++) begin
      val[i] = 24'($urandom);
      host.xfer(8'h1D + 8'(i), val[i]);
    end
    val[6] = 24'h000000;
    chk("gain32", val[0], gain.gain32);
    chk("gain64", val[1], gain.gain64);
    chk("gain128", val[2], gain.gain128);
    for (int i = 0; i < 7; i++) rd(8'h1D + 8'(i), val[i]);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      uni <= m[0];
      off <= m[1];
      for (int c = 0; c < NUM_CH; c++) begin
        lim[c] = 24'($urandom);
        host.xfer(8'h20 + 8'(c), lim[c]);
      end
      for (int k = 0; k < 20; k++) begin
        @(posedge clk);
        for (int c = 0; c < NUM_CH; c++) begin
          res[c] <= (k == 0) ? lim[c] : (k == 1) ? lim[c] - 24'h000001 :
                    (k == 2) ? ((m == 0) ? 24'h7FFFFF : 24'hFFFFFF) : 24'($urandom);
        end
        repeat (2) @(posedge clk);
        for (int c = 0; c < NUM_CH; c++) begin
          chk("flag", 24'(key(res[c]) < key(lim[c])), 24'(flag[c]));
        end
      end
    end
    stop_test;
  end
endmodule : agt_regs_test
